// ---- src/seep_cmd_port.sv ----
/*
 * Serial EEPROM command port: opcode decoder, array and status access,
 * page buffer, write latch, hold pause and self-timed write cycle.
 * Assumes every serial pin is asynchronous and far slower than ref_clk_i.
 */
`timescale 1ns/1ps
module seep_cmd_port
   import seep_pkg::*;
#(
   parameter int WRITE_CYCLES = WRITE_CYC
) (
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   input  wire logic cs_n_i,
   input  wire logic sck_i,
   input  wire logic si_i,
   input  wire logic hold_n_i,
   input  wire logic wp_n_i,
   output logic      so_o,
   output logic      so_oe_o,
   output logic      write_latch_flag_o,
   output logic      write_busy_flag_o
);

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [4:0] pin_s;
   logic       cs_s;
   logic       sck_s;
   logic       si_s;
   logic       hold_s;
   logic       wp_s;

   // Select, hold and protect idle high; clock and data idle low
   seep_sync #(.W(5), .RST_VAL(5'h13)) u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .d_i       ({cs_n_i, sck_i, si_i, hold_n_i, wp_n_i}),
      .q_o       (pin_s)
   );

   assign cs_s   = pin_s[4];
   assign sck_s  = pin_s[3];
   assign si_s   = pin_s[2];
   assign hold_s = pin_s[1];
   assign wp_s   = pin_s[0];

   // ************************************************************
   // Edge finding and hold pause
   // ************************************************************
   logic sck_q;
   logic cs_q;
   logic paused;
   logic active;
   logic sck_rise;
   logic sck_fall;
   logic cs_rise;

   // Previous samples for edge detection
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sck_q <= 1'b0;
         cs_q  <= 1'b1;
      end else if (ce_i) begin
         sck_q <= sck_s;
         cs_q  <= cs_s;
      end
   end

   // Pause begins only while the serial clock is low; it ends with clock low or at deselect
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         paused <= 1'b0;
      end else if (ce_i) begin
         if (cs_s) begin
            paused <= 1'b0;
         end else if (!paused && !hold_s && !sck_s) begin
            paused <= 1'b1;
         end else if (paused && hold_s && !sck_s) begin
            paused <= 1'b0;
         end
      end
   end

   // Rises need hold high; a fall still counts until the pause has begun
   assign active   = !cs_s && hold_s && !paused;
   assign sck_rise = active && sck_s && !sck_q;
   assign sck_fall = !cs_s && !paused && !sck_s && sck_q;
   assign cs_rise  = cs_s && !cs_q;

   // ************************************************************
   // Storage
   // ************************************************************
   logic [7:0]        mem [0:(1<<ADDR_W)-1];
   logic [7:0]        pg_data [0:PAGE_BYTES-1];
   logic [PAGE_BYTES-1:0] pg_mask;
   logic              pin_en;
   logic [1:0]        bp;
   logic              wr_latch;
   logic              busy;
   logic              copying;
   logic [31:0]       bcnt;
   logic [PAGE_W-1:0] cp_idx;
   logic [ADDR_W-PAGE_W-1:0] pg_base;

   // ************************************************************
   // Serial engine
   // ************************************************************
   seep_state_t       state;
   logic [2:0]        bit_idx;
   logic [7:0]        shreg;
   logic [7:0]        stat_buf;
   logic [7:0]        out_sr;
   logic [ADDR_W-1:0] ptr;
   logic              is_read;
   logic              is_status;
   logic              addr_hi;
   logic              byte_done;
   logic              data_seen;
   logic              spoil;
   logic              pend_set;
   logic              pend_clr;
   logic              out_live;
   logic [7:0]        next_byte;
   logic [7:0]        stat_word;

   assign next_byte = {shreg[6:0], si_s};
   assign stat_word = {pin_en, 3'h0, bp, wr_latch, busy};

   // Shifting in on rise, out on fall; deselect restarts the sequence
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state     <= ST_OPC;
         bit_idx   <= 3'h0;
         shreg     <= 8'h00;
         stat_buf  <= 8'h00;
         out_sr    <= 8'h00;
         ptr       <= '0;
         is_read   <= 1'b0;
         is_status <= 1'b0;
         addr_hi   <= 1'b0;
         byte_done <= 1'b0;
         data_seen <= 1'b0;
         spoil     <= 1'b0;
         pend_set  <= 1'b0;
         pend_clr  <= 1'b0;
         out_live  <= 1'b0;
         pg_mask   <= '0;
      end else if (ce_i) begin
         if (cs_s) begin
            state     <= ST_OPC;
            bit_idx   <= 3'h0;
            is_status <= 1'b0;
            addr_hi   <= 1'b0;
            byte_done <= 1'b0;
            data_seen <= 1'b0;
            spoil     <= 1'b0;
            pend_set  <= 1'b0;
            pend_clr  <= 1'b0;
            out_live  <= 1'b0;
         end else if (sck_rise) begin
            shreg     <= next_byte;
            bit_idx   <= bit_idx + 3'h1;
            byte_done <= (bit_idx == 3'h7);
            if (state == ST_SKIP) begin
               spoil <= 1'b1;
            end
            if (bit_idx == 3'h7) begin
               case (state)
                  ST_OPC: begin
                     case (next_byte)
                        OP_READ: begin
                           is_read <= 1'b1;
                           state   <= busy ? ST_SKIP : ST_ADDR;
                        end
                        OP_WRITE: begin
                           is_read <= 1'b0;
                           state   <= busy ? ST_SKIP : ST_ADDR;
                           // Fresh mask per command; a copy in flight keeps its own
                           if (!busy) begin
                              pg_mask <= '0;
                           end
                        end
                        OP_LATCH_ST: begin
                           pend_set <= !busy;
                           state    <= ST_SKIP;
                        end
                        OP_LATCH_CL: begin
                           pend_clr <= !busy;
                           state    <= ST_SKIP;
                        end
                        OP_STAT_RD: begin
                           state <= ST_STAT;
                        end
                        OP_STAT_WR: begin
                           is_status <= 1'b1;
                           state     <= busy ? ST_SKIP : ST_WDATA;
                        end
                        default: begin
                           state <= ST_SKIP;
                        end
                     endcase
                  end
                  ST_ADDR: begin
                     if (!addr_hi) begin
                        addr_hi <= 1'b1;
                        ptr[ADDR_W-1:8] <= next_byte[ADDR_W-9:0];
                     end else begin
                        ptr[7:0] <= next_byte;
                        state    <= is_read ? ST_RDATA : ST_WDATA;
                     end
                  end
                  ST_WDATA: begin
                     data_seen <= 1'b1;
                     if (is_status) begin
                        stat_buf <= next_byte;
                     end else begin
                        pg_data[ptr[PAGE_W-1:0]] <= next_byte;
                        pg_mask[ptr[PAGE_W-1:0]] <= 1'b1;
                        // Wrap inside the page, base bits untouched
                        ptr[PAGE_W-1:0] <= ptr[PAGE_W-1:0] + 5'h01;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end else if (sck_fall && (state == ST_RDATA || state == ST_STAT)) begin
            out_live <= 1'b1;
            if (bit_idx == 3'h0) begin
               if (state == ST_RDATA) begin
                  out_sr <= mem[ptr];
                  ptr    <= ptr + 13'h0001;
               end else begin
                  out_sr <= stat_word;
               end
            end else begin
               out_sr <= {out_sr[6:0], 1'b0};
            end
         end
      end
   end

   // Data from a flop; enable dropped at once by hold or deselect
   assign so_o    = out_sr[7];
   assign so_oe_o = active && out_live &&
                    (state == ST_RDATA || state == ST_STAT);

   // ************************************************************
   // Commit decode
   // ************************************************************
   logic commit_ok;
   logic hw_lock;
   logic arr_commit;
   logic st_commit;

   // Only a rise straight after a whole data byte commits
   assign commit_ok  = cs_rise && (state == ST_WDATA) && byte_done &&
                       data_seen && wr_latch && !busy;
   assign hw_lock    = pin_en && !wp_s;
   assign arr_commit = commit_ok && !is_status;
   assign st_commit  = commit_ok && is_status && !hw_lock;

   // ************************************************************
   // Status bits
   // ************************************************************
   // Nonvolatile protect bits change only on an accepted status write
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_en <= PEN_RST;
         bp     <= BP_RST;
      end else if (ce_i && st_commit) begin
         pin_en <= stat_buf[ST_PEN_BIT];
         bp     <= stat_buf[ST_BP_HI:ST_BP_LO];
      end
   end

   // Write latch: set or cleared on deselect after an exact opcode
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_latch <= 1'b0;
      end else if (ce_i) begin
         if (busy && bcnt == 32'h0) begin
            wr_latch <= 1'b0;
         end else if (cs_rise && !spoil && !busy) begin
            if (pend_set) begin
               wr_latch <= 1'b1;
            end else if (pend_clr) begin
               wr_latch <= 1'b0;
            end
         end
      end
   end

   // ************************************************************
   // Self-timed write cycle
   // ************************************************************
   // Settings are latched at start, so protect pin changes later are moot
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy    <= 1'b0;
         copying <= 1'b0;
         bcnt    <= 32'h0;
         cp_idx  <= '0;
         pg_base <= '0;
      end else if (ce_i) begin
         if (arr_commit || st_commit) begin
            busy    <= 1'b1;
            bcnt    <= 32'(WRITE_CYCLES - 1);
            copying <= arr_commit;
            cp_idx  <= '0;
            pg_base <= ptr[ADDR_W-1:PAGE_W];
         end else if (busy) begin
            if (bcnt == 32'h0) begin
               busy <= 1'b0;
            end else begin
               bcnt <= bcnt - 32'h1;
            end
            if (copying) begin
               cp_idx <= cp_idx + 5'h01;
               if (cp_idx == 5'h1F) begin
                  copying <= 1'b0;
               end
            end
         end
      end
   end

   // Page buffer into the array, one byte a cycle, skipping locked bytes
   always_ff @(posedge ref_clk_i) begin
      if (ce_i && copying && pg_mask[cp_idx] &&
          !seep_locked(bp, {pg_base, cp_idx})) begin
         mem[{pg_base, cp_idx}] <= pg_data[cp_idx];
      end
   end

   assign write_latch_flag_o = wr_latch;
   assign write_busy_flag_o  = busy;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   a_hold_float: assert property (!hold_s |-> !so_oe_o)
      else $error("output driven while hold is low");

   a_pause_float: assert property (paused |-> !so_oe_o && !sck_rise)
      else $error("activity while paused");

   a_busy_start: assert property (
      ce_i && (arr_commit || st_commit) |=>
         busy && bcnt == 32'(WRITE_CYCLES - 1))
      else $error("write cycle did not start with full count");

   a_busy_end: assert property (
      ce_i && busy && bcnt == 32'h0 |=> !busy && !wr_latch)
      else $error("write cycle end wrong");

   a_wp_lock: assert property (
      cs_rise && is_status && hw_lock |=> $stable({pin_en, bp}))
      else $error("status changed while pin protected");

   a_wp_ignored: assert property (
      ce_i && commit_ok && is_status && !pin_en |=> busy)
      else $error("status write refused with pin disabled");

   a_read_wrap: assert property (
      ce_i && sck_fall && state == ST_RDATA && bit_idx == 3'h0 &&
      ptr == 13'h1FFF |=> ptr == 13'h0000)
      else $error("read pointer did not wrap");

   a_page_wrap: assert property (
      ce_i && sck_rise && state == ST_WDATA && !is_status &&
      bit_idx == 3'h7 |=> ptr[ADDR_W-1:PAGE_W] == $past(ptr[ADDR_W-1:PAGE_W]))
      else $error("write pointer left its page");

   a_so_on_fall: assert property (
      $changed(so_o) |-> $past(sck_fall))
      else $error("output changed without a clock fall");

   a_no_array_busy: assert property (busy |-> state != ST_RDATA)
      else $error("array read during write cycle");

endmodule // seep_cmd_port

// ---- src/seep_pkg.sv ----
/*
 * Constants, types and helpers shared by the serial EEPROM command port.
 * Assumes a 50 MHz system clock that oversamples every serial pin.
 */
// How it works
// - Status nonvolatile bits refuse writes while the protect pin is low and enabled.
// - A started internal write always completes whatever the protect pin does.
// - With the pin enable bit clear the protect pin is ignored.
// - Input bits taken on clock rise; output bits change after clock fall.
// - Hold falling with clock high pauses only at the next clock fall.
// - Paused: output floats, input and clock ignored, position kept.
// - Hold rising with clock low resumes the interrupted sequence.
// - Hold low always floats the serial output.
// - Every field travels most significant bit first.
// - First opcode bit taken on first clock rise after select falls.
// - Opcode 03h reads the array, 02h writes it, address follows.
// - Opcode 04h clears the latch, 06h sets it, 05h reads status.
// - Opcode 01h writes status; success clears the write latch.
// - Opcode then 16 address bits; the top three address bits ignored.
// - Read pointer advances per byte and wraps from 1FFFh to 0000h.
// - Read runs until select rises, which stops shifting.
// - Latch set needs select raised after exactly the full opcode.
// - Up to 32 data bytes per write, kept inside one page.
// - Data past the page end wraps to the start of that page.
// - Write starts only if select rises right after a whole byte.
// - During a write cycle status reads work, array reads do not.
// - Latch clears at reset, on clear command and at write end.
// - Busy flag is one during an internal write, zero otherwise.
// - Two protect bits guard none, upper quarter, upper half or all.
// - Array commands during a write cycle are ignored.
package seep_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_FREQ_HZ   = 50_000_000;
   localparam int WRITE_TIME_US = 5000;
   localparam int WRITE_CYC     = WRITE_TIME_US * (CLK_FREQ_HZ / 1_000_000);

   // ************************************************************
   // Geometry and opcodes
   // ************************************************************
   localparam int ADDR_W     = 13;
   localparam int PAGE_W     = 5;
   localparam int PAGE_BYTES = 32;
   localparam logic [7:0] OP_READ     = 8'h03;
   localparam logic [7:0] OP_WRITE    = 8'h02;
   localparam logic [7:0] OP_LATCH_CL = 8'h04;
   localparam logic [7:0] OP_LATCH_ST = 8'h06;
   localparam logic [7:0] OP_STAT_RD  = 8'h05;
   localparam logic [7:0] OP_STAT_WR  = 8'h01;

   // ************************************************************
   // Status layout and reset values
   // ************************************************************
   localparam int ST_PEN_BIT  = 7;
   localparam int ST_BP_HI    = 3;
   localparam int ST_BP_LO    = 2;
   localparam logic       PEN_RST  = 1'h0;
   localparam logic [1:0] BP_RST   = 2'h0;
   localparam logic [ADDR_W-1:0] QUARTER_BASE = 13'h1800;
   localparam logic [ADDR_W-1:0] HALF_BASE    = 13'h1000;

   typedef enum logic [2:0] {
      ST_OPC   = 3'b000,
      ST_ADDR  = 3'b001,
      ST_WDATA = 3'b011,
      ST_RDATA = 3'b010,
      ST_STAT  = 3'b110,
      ST_SKIP  = 3'b111
   } seep_state_t;

   // Block protection decode
   function automatic logic seep_locked(input logic [1:0] bp,
                                        input logic [ADDR_W-1:0] a);
      case (bp)
         2'h1:    seep_locked = (a >= QUARTER_BASE);
         2'h2:    seep_locked = (a >= HALF_BASE);
         2'h3:    seep_locked = 1'b1;
         default: seep_locked = 1'b0;
      endcase
   endfunction

endpackage

// ---- src/seep_sync.sv ----
/*
 * Two-stage synchroniser for a group of pin inputs.
 * Assumes the pins are asynchronous to ref_clk_i.
 */
`timescale 1ns/1ps
module seep_sync #(
   parameter int           W       = 5,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input  wire logic         ref_clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta;

   // ************************************************************
   // Two flops per bit
   // ************************************************************
   // Preset per bit matches each pin's idle level, so no false edge follows reset
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
               meta[i] <= RST_VAL[i];
               q_o[i]  <= RST_VAL[i];
            end else if (ce_i) begin
               meta[i] <= d_i[i];
               q_o[i]  <= meta[i];
            end
         end
      end
   endgenerate
endmodule // seep_sync

// ---- verif/seep_host.sv ----
/*
 * Host side model of the serial link: select, clock, data and hold.
 * Assumes ref_clk_i is the port's system clock; one link clock is 8 of its cycles.
 */
`timescale 1ns/1ps
module seep_host (
   input  wire logic ref_clk_i,
   input  wire logic so_i,
   input  wire logic so_oe_i,
   output logic      cs_n_o,
   output logic      sck_o,
   output logic      si_o,
   output logic      hold_n_o
);
   logic last_so;
   logic oe_seen;
   logic hold_oe;
   // Released output shows the inverse of its last driven level
   wire  so_w = so_oe_i ? so_i : ~last_so;

   // ****************************************
   // Idle levels and output watch
   // ****************************************
   initial begin
      cs_n_o   = 1'b1;
      sck_o    = 1'b0;
      si_o     = 1'b0;
      hold_n_o = 1'b1;
      last_so  = 1'b0;
      hold_oe  = 1'b0;
   end
   // Remember whether the port drove its output since select
   always @(posedge ref_clk_i) begin
      if (so_oe_i) begin
         last_so <= so_i;
         oe_seen <= 1'b1;
      end
   end

   // ****************************************
   // Link tasks
   // ****************************************
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   // Clock stands low outside frames
   task automatic sel();
      tick(1);
      cs_n_o  <= 1'b0;
      oe_seen <= 1'b0;
      tick(4);
   endtask
   task automatic desel();
      tick(4);
      cs_n_o <= 1'b1;
      tick(6);
   endtask
   // Data set while clock low; read back late in the high phase, where it is settled
   // With hi set, hold drops while the clock is still high
   task automatic bit1(input logic b, output logic r, input bit hi);
      si_o <= b;
      tick(4);
      sck_o <= 1'b1;
      tick(4);
      r = so_w;
      if (hi) begin
         hold_n_o <= 1'b0;
         tick(2);
      end
      sck_o <= 1'b0;
   endtask
   // Hold only with clock low; select stays low; clock pulses meanwhile must be ignored
   task automatic pause();
      tick(2);
      hold_n_o <= 1'b0;
      tick(6);
      hold_oe = so_oe_i;
      sck_o <= 1'b1;
      tick(4);
      sck_o <= 1'b0;
      tick(4);
      hold_n_o <= 1'b1;
      tick(4);
   endtask
   // Hold mode: 0 none, 1 hold with clock low, 2 hold with clock high
   task automatic xfer(input logic [7:0] tx, input bit [1:0] hold, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         bit1(tx[i], rx[i], hold[1] && i == 4);
         if (hold != 2'h0 && i == 4) pause();
      end
   endtask
endmodule // seep_host

// ---- verif/seep_cmd_port_test.sv ----
/*
 * Self-checking bench of the serial command port against a byte-array model.
 * Assumes seep_host drives the link; write time shortened to 1000 cycles.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module seep_cmd_port_test;
   import seep_pkg::*;
   localparam int WCYC = 1000;
   logic       ref_clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       wp_n_i = 1'b1;
   logic       cs_n, sck, si, hold_n, so, so_oe, wlf, wbf;
   int         bad_count = 0;
   int         num_checks = 0;
   logic [7:0] mem [int];
   logic       pin_en = 1'b0;
   logic [1:0] bp = 2'h0;
   logic       latch = 1'b0;
   logic       busy = 1'b0;
   logic [7:0] r;
   wire  [2:0] flags = {wlf, wbf, so_oe};

   always #10 ref_clk_i = ~ref_clk_i;

   seep_cmd_port #(.WRITE_CYCLES(WCYC)) i_seep_cmd_port (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .ce_i(1'b1), .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n_i),
      .so_o(so), .so_oe_o(so_oe), .write_latch_flag_o(wlf), .write_busy_flag_o(wbf));
   seep_host i_seep_host (.ref_clk_i(ref_clk_i), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n),
      .sck_o(sck), .si_o(si), .hold_n_o(hold_n));

   // ****************************************
   // Model and transfer tasks
   // ****************************************
   function automatic logic locked(input logic [12:0] a);
      return (bp == 2'h3) || (bp == 2'h2 && a[12]) || (bp == 2'h1 && a[12:11] == 2'h3);
   endfunction
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Single opcode selection; only issued while idle
   task automatic op(input logic [7:0] o);
      i_seep_host.sel();
      i_seep_host.xfer(o, 0, r);
      i_seep_host.desel();
      if (o == OP_LATCH_ST) latch = 1'b1;
      if (o == OP_LATCH_CL) latch = 1'b0;
      `CHK("latch", latch, wlf)
   endtask
   // Extra loose bits after the data make a partial byte, which must abort
   task automatic wr(input logic [15:0] a, input int n, input int extra);
      logic [23:0] h = {OP_WRITE, a};
      logic [7:0]  d;
      logic [12:0] p;
      i_seep_host.sel();
      for (int i = 2; i >= 0; i--) i_seep_host.xfer(h[i*8 +: 8], 0, r);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         i_seep_host.xfer(d, 0, r);
         p = {a[12:5], a[4:0] + i[4:0]};
         if (extra == 0 && latch && !busy && !locked(p)) mem[p] = d;
      end
      for (int i = 0; i < extra; i++) i_seep_host.bit1(1'b1, r[0], 1'b0);
      i_seep_host.desel();
      if (extra == 0 && latch) busy = 1'b1;
      `CHK("busy", busy, wbf)
   endtask
   task automatic wait_idle();
      int k = 0;
      while (wbf !== 1'b0 && k < 3000) begin
         @(posedge ref_clk_i);
         k++;
      end
      if (k == 3000) begin
         bad_count++;
         test_done();
      end
      if (busy) begin
         latch = 1'b0;
         `CHK("latch", latch, wlf)
      end
      busy = 1'b0;
   endtask
   task automatic rd_stat();
      logic [7:0] e;
      i_seep_host.sel();
      i_seep_host.xfer(OP_STAT_RD, 0, r);
      i_seep_host.xfer(8'h00, 0, r);
      i_seep_host.desel();
      e = {pin_en, 3'b000, bp, latch, busy};
      `CHK("status", e, r)
   endtask
   task automatic stat_wr(input logic [7:0] v);
      op(OP_LATCH_ST);
      i_seep_host.sel();
      i_seep_host.xfer(OP_STAT_WR, 0, r);
      i_seep_host.xfer(v, 0, r);
      i_seep_host.desel();
      if (!(pin_en && !wp_n_i)) begin
         pin_en = v[7];
         bp   = v[3:2];
         busy = 1'b1;
      end
   endtask
   task automatic rd_arr(input logic [15:0] a, input int n, input bit [1:0] hold);
      logic [23:0] h = {OP_READ, a};
      logic [12:0] p;
      i_seep_host.sel();
      for (int i = 2; i >= 0; i--) i_seep_host.xfer(h[i*8 +: 8], 0, r);
      for (int i = 0; i < n; i++) begin
         p = a[12:0] + i[12:0];
         i_seep_host.xfer(8'h00, (i == 1) ? hold : 2'h0, r);
         if (!busy && mem.exists(p)) `CHK("array", mem[p], r)
      end
      i_seep_host.desel();
      if (busy) `CHK("read_oe", 1'b0, i_seep_host.oe_seen)
      if (hold != 2'h0) `CHK("hold_oe", 1'b0, i_seep_host.hold_oe)
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      void'($urandom(32'h6902));
      repeat (12) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      `CHK("reset", 3'b000, flags)
      rd_stat();
      op(OP_LATCH_ST);
      op(OP_LATCH_CL);
      wr(16'hFFFE, 4, 0);
      op(OP_LATCH_ST);
      wr(16'h0000, 32, 0);
      wait_idle();
      op(OP_LATCH_ST);
      wr(16'hFFFE, 4, 0);
      wr(16'h0010, 1, 0);
      rd_stat();
      rd_arr(16'h1FFE, 1, 0);
      wait_idle();
      rd_arr(16'hFFFE, 4, 1);
      rd_arr(16'h1FE0, 2, 2);
      rd_arr(16'h000F, 2, 0);
      op(OP_LATCH_ST);
      wr(16'h0005, 1, 3);
      op(OP_LATCH_CL);
      // Latch set and write in one selection: nothing may land
      i_seep_host.sel();
      for (int i = 0; i < 5; i++) i_seep_host.xfer(i == 0 ? OP_LATCH_ST : OP_WRITE, 0, r);
      i_seep_host.desel();
      `CHK("same_sel", 3'b000, flags)
      rd_arr(16'h0005, 1, 0);
      op(OP_LATCH_ST);
      wr(16'h1800, 1, 0);
      wait_idle();
      for (int v = 0; v < 4; v++) begin
         stat_wr(8'(v << 2));
         wait_idle();
         rd_stat();
      end
      stat_wr(8'h04);
      wait_idle();
      op(OP_LATCH_ST);
      wr(16'h17FE, 2, 0);
      wait_idle();
      op(OP_LATCH_ST);
      wr(16'h1800, 1, 0);
      wait_idle();
      rd_arr(16'h17FE, 3, 0);
      stat_wr(8'h84);
      wp_n_i <= 1'b0;
      wait_idle();
      rd_stat();
      stat_wr(8'h80);
      wait_idle();
      op(OP_LATCH_CL);
      rd_stat();
      wp_n_i <= 1'b1;
      stat_wr(8'h00);
      wait_idle();
      wp_n_i <= 1'b0;
      stat_wr(8'h08);
      wait_idle();
      rd_stat();
      test_done();
   end
endmodule // seep_cmd_port_test
